// ---- hdl/pmc_wake_filter.sv ----
// Wake source filter: picks the resets and interrupts that end each low power state
`timescale 1ns/1ps
module pmc_wake_filter #(
   parameter int IRQ_W = 8
) (
   input wire logic i_pin_reset,
   input wire logic i_por_reset,
   input wire logic i_lvd_reset,
   input wire logic [IRQ_W-1:0] i_irq,
   input wire logic [IRQ_W-1:0] i_standby_wake_en,
   input wire logic [IRQ_W-1:0] i_deep_wake_en,
   pmc_wake_if.filter wk
);
   wire any_irq;
   wire standby_irq;
   wire deep_irq;

   // Sleep wakes on any interrupt; standby states only on enabled sources
   assign any_irq = |i_irq;
   assign standby_irq = |(i_irq & i_standby_wake_en);
   assign deep_irq = |(i_irq & i_deep_wake_en);
   assign wk.reset_wake = i_pin_reset | i_por_reset | i_lvd_reset; // R05
   assign wk.irq_wake = (wk.state == pmc_pkg::ST_SLEEP) ? any_irq :
      (wk.state == pmc_pkg::ST_SW_STANDBY || wk.state == pmc_pkg::ST_SNOOZE) ? standby_irq :
      (wk.state == pmc_pkg::ST_DEEP_STANDBY) ? deep_irq : 1'b0; // R05
endmodule // pmc_wake_filter

// ---- hdl/power_mode_controller.sv ----
// Power mode controller: operating power mode and low power state sequencing
`timescale 1ns/1ps
// Contract
// R01: Software writes an operating power mode used in Normal and Sleep.
// R02: High-speed allows all oscillators; low-speed no PLLs; subosc only three slow ones.
// R03: Any mode value is accepted (the code drops reserved code 3); savings depend on software clock and voltage setup.
// R04: Software should choose the largest clock division ratios for lowest power.
// R05: Pin, power-on, voltage monitor reset or enabled interrupt leaves low power.
// R06: Snooze is entered only from Software Standby on a snooze trigger.
// R07: Other low power modes entered only on wait-for-interrupt, selected by standby bits.
// R08: The operating power setting encodes exactly three modes.
// R09: Interrupt wake resumes execution, except deep standby wake which forces reset.
// R10: A reset that cancels any low power mode leaves the device in reset.
// R11: Select clear gives Sleep; select set gives Standby, or Deep with deep bit.
module power_mode_controller #(
   parameter int IRQ_W = 8
) (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_opc_we,
   input wire logic [1:0] i_opc_wdata,
   input wire logic i_standby_select_bit,
   input wire logic i_deep_standby_bit,
   input wire logic i_snooze_enable_bit,
   input wire logic i_wait_for_interrupt_instr,
   input wire logic i_snooze_trigger,
   input wire logic i_pin_reset,
   input wire logic i_por_reset,
   input wire logic i_lvd_reset,
   input wire logic [IRQ_W-1:0] i_irq,
   input wire logic [IRQ_W-1:0] i_standby_wake_en,
   input wire logic [IRQ_W-1:0] i_deep_wake_en,
   output logic [1:0] o_operating_power_ctrl_reg,
   output logic [pmc_pkg::OSC_COUNT-1:0] o_osc_allowed,
   output logic [2:0] o_power_state,
   output logic o_cpu_clock_run,
   output logic o_irq_resume,
   output logic o_system_reset_req
);
   typedef enum logic [2:0] {S_NORMAL, S_SLEEP, S_SW_STANDBY, S_SNOOZE, S_DEEP} pstate_e;

   pstate_e state_reg;
   pstate_e state_next;
   logic [1:0] opc_reg;
   logic [3:0] rst_cnt_reg;
   logic [3:0] rst_cnt_next;
   logic resume_reg;
   logic resume_next;
   logic [2:0] state_code;
   wire opc_legal;
   wire in_low_power;
   wire deep_irq_exit;
   wire irq_exit;
   pmc_wake_if wk ();

   // Map the internal state to its status code
   function automatic logic [2:0] code_of(input pstate_e s);
      case (s)
         S_SLEEP: code_of = pmc_pkg::ST_SLEEP;
         S_SW_STANDBY: code_of = pmc_pkg::ST_SW_STANDBY;
         S_SNOOZE: code_of = pmc_pkg::ST_SNOOZE;
         S_DEEP: code_of = pmc_pkg::ST_DEEP_STANDBY;
         default: code_of = pmc_pkg::ST_NORMAL;
      endcase
   endfunction

   // Oscillators permitted by each operating power mode
   function automatic logic [pmc_pkg::OSC_COUNT-1:0] osc_mask(input logic [1:0] m);
      case (m)
         pmc_pkg::OPC_LOW_SPEED: osc_mask = pmc_pkg::OSC_ALLOW_LOW; // R02
         pmc_pkg::OPC_SUBOSC_SPEED: osc_mask = pmc_pkg::OSC_ALLOW_SUBOSC; // R02
         default: osc_mask = pmc_pkg::OSC_ALLOW_HIGH; // R02
      endcase
   endfunction

   pmc_wake_filter #(.IRQ_W(IRQ_W)) u_wake (
      .i_pin_reset(i_pin_reset),
      .i_por_reset(i_por_reset),
      .i_lvd_reset(i_lvd_reset),
      .i_irq(i_irq),
      .i_standby_wake_en(i_standby_wake_en),
      .i_deep_wake_en(i_deep_wake_en),
      .wk(wk.filter)
   );

   // Decode of state and wake conditions
   assign state_code = code_of(state_reg);
   assign wk.state = state_code;
   // Reserved code 3 is dropped so the register only ever holds three modes
   assign opc_legal = (i_opc_wdata != 2'h3); // R08
   assign in_low_power = (state_reg != S_NORMAL);
   assign irq_exit = in_low_power && wk.irq_wake;
   assign deep_irq_exit = (state_reg == S_DEEP) && wk.irq_wake; // R09

   // Low power state sequencing
   always_comb begin
      state_next = state_reg;
      resume_next = 1'b0;
      rst_cnt_next = (rst_cnt_reg != 4'h0) ? rst_cnt_reg - 4'h1 : 4'h0;
      case (state_reg)
         S_NORMAL: begin
            if (i_wait_for_interrupt_instr && rst_cnt_reg == 4'h0) begin // R07
               if (!i_standby_select_bit) begin
                  state_next = S_SLEEP; // R11
               end else if (!i_deep_standby_bit) begin
                  state_next = S_SW_STANDBY; // R11
               end else begin
                  state_next = S_DEEP; // R11
               end
            end
         end
         S_SW_STANDBY: begin
            if (irq_exit) begin
               state_next = S_NORMAL;
               resume_next = 1'b1; // R09
            end else if (i_snooze_trigger && i_snooze_enable_bit) begin
               state_next = S_SNOOZE; // R06
            end
         end
         S_SLEEP, S_SNOOZE: begin
            if (irq_exit) begin
               state_next = S_NORMAL;
               resume_next = 1'b1; // R09
            end
         end
         S_DEEP: begin
            if (deep_irq_exit) begin
               state_next = S_NORMAL;
               rst_cnt_next = pmc_pkg::WAKE_RESET_CYCLES; // R09
            end
         end
         default: state_next = S_NORMAL;
      endcase
      // Resets take priority over every interrupt wake
      if (wk.reset_wake) begin
         state_next = S_NORMAL; // R10
         resume_next = 1'b0;
         rst_cnt_next = pmc_pkg::WAKE_RESET_CYCLES; // R10
      end
   end

   // State registers
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         state_reg <= S_NORMAL;
         resume_reg <= 1'b0;
         rst_cnt_reg <= 4'h0;
      end else begin
         state_reg <= state_next;
         resume_reg <= resume_next;
         rst_cnt_reg <= rst_cnt_next;
      end
   end

   // Operating power mode register; writable any time, no clock check
   always_ff @(posedge i_clk) begin
      if (i_reset || wk.reset_wake) begin
         opc_reg <= pmc_pkg::OPC_RESET_VALUE;
      end else if (i_opc_we && opc_legal) begin
         opc_reg <= i_opc_wdata; // R01 R03
      end
   end

   // Outputs
   assign o_operating_power_ctrl_reg = opc_reg;
   // Low power states beyond sleep stop every oscillator but the slow trio
   assign o_osc_allowed = (state_reg == S_NORMAL || state_reg == S_SLEEP) ?
      osc_mask(opc_reg) : pmc_pkg::OSC_ALLOW_SUBOSC; // R02
   assign o_power_state = state_code;
   assign o_cpu_clock_run = (state_reg == S_NORMAL) && (rst_cnt_reg == 4'h0);
   assign o_irq_resume = resume_reg; // R09
   assign o_system_reset_req = (rst_cnt_reg != 4'h0); // R10

   // Checks
   property p_sleep_entry;
      @(posedge i_clk) disable iff (i_reset)
      (state_reg == S_NORMAL && i_wait_for_interrupt_instr && rst_cnt_reg == 4'h0 &&
       !i_standby_select_bit && !wk.reset_wake) |=> (o_power_state == pmc_pkg::ST_SLEEP);
   endproperty
   a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered"); // R11

   property p_deep_entry;
      @(posedge i_clk) disable iff (i_reset)
      (state_reg == S_NORMAL && i_wait_for_interrupt_instr && rst_cnt_reg == 4'h0 &&
       i_standby_select_bit && i_deep_standby_bit && !wk.reset_wake)
      |=> (o_power_state == pmc_pkg::ST_DEEP_STANDBY);
   endproperty
   a_deep_entry: assert property (p_deep_entry) else $error("deep standby not entered"); // R11

   property p_snooze_origin;
      @(posedge i_clk) disable iff (i_reset)
      (o_power_state == pmc_pkg::ST_SNOOZE && $past(o_power_state) != pmc_pkg::ST_SNOOZE)
      |-> ($past(o_power_state) == pmc_pkg::ST_SW_STANDBY && $past(i_snooze_trigger));
   endproperty
   a_snooze_origin: assert property (p_snooze_origin) else $error("bad snooze entry"); // R06

   property p_lp_needs_wait;
      @(posedge i_clk) disable iff (i_reset)
      ($past(o_power_state) == pmc_pkg::ST_NORMAL && o_power_state != pmc_pkg::ST_NORMAL)
      |-> $past(i_wait_for_interrupt_instr);
   endproperty
   a_lp_needs_wait: assert property (p_lp_needs_wait) else $error("entry without wait instr"); // R07

   sequence s_reset_in_lp;
      in_low_power && wk.reset_wake;
   endsequence
   property p_reset_cancel;
      @(posedge i_clk) disable iff (i_reset)
      s_reset_in_lp |=> (o_power_state == pmc_pkg::ST_NORMAL && o_system_reset_req)[*4];
   endproperty
   a_reset_cancel: assert property (p_reset_cancel) else $error("reset cancel wrong"); // R10

   property p_deep_irq_reset;
      @(posedge i_clk) disable iff (i_reset)
      (deep_irq_exit && !wk.reset_wake) |=> (o_system_reset_req && !o_irq_resume);
   endproperty
   a_deep_irq_reset: assert property (p_deep_irq_reset) else $error("deep wake no reset"); // R09

   property p_irq_resume;
      @(posedge i_clk) disable iff (i_reset)
      (irq_exit && state_reg != S_DEEP && !wk.reset_wake)
      |=> (o_irq_resume && o_power_state == pmc_pkg::ST_NORMAL);
   endproperty
   a_irq_resume: assert property (p_irq_resume) else $error("irq wake no resume"); // R05

   property p_opc_three;
      @(posedge i_clk) disable iff (i_reset)
      (o_operating_power_ctrl_reg != 2'h3);
   endproperty
   a_opc_three: assert property (p_opc_three) else $error("illegal power mode"); // R08

   property p_opc_write;
      @(posedge i_clk) disable iff (i_reset)
      (i_opc_we && opc_legal && !wk.reset_wake)
      |=> (o_operating_power_ctrl_reg == $past(i_opc_wdata));
   endproperty
   a_opc_write: assert property (p_opc_write) else $error("mode write lost"); // R01

   property p_no_pll_low;
      @(posedge i_clk) disable iff (i_reset)
      (o_operating_power_ctrl_reg != pmc_pkg::OPC_HIGH_SPEED) |->
      (!o_osc_allowed[pmc_pkg::OSC_PLL] && !o_osc_allowed[pmc_pkg::OSC_PLL_B] &&
       o_osc_allowed[pmc_pkg::OSC_LOCO]);
   endproperty
   a_no_pll_low: assert property (p_no_pll_low) else $error("pll allowed in low mode"); // R02
endmodule // power_mode_controller

// ---- include/pmc_pkg.sv ----
// Package with mode encodings and field constants for the power mode controller
package pmc_pkg;
   // Operating power control encodings (two bits, three legal values)
   localparam logic [1:0] OPC_HIGH_SPEED = 2'h0;
   localparam logic [1:0] OPC_LOW_SPEED = 2'h1;
   localparam logic [1:0] OPC_SUBOSC_SPEED = 2'h2;
   localparam logic [1:0] OPC_RESET_VALUE = 2'h0;
   // Oscillator enable vector bit positions
   localparam int OSC_PLL = 0;
   localparam int OSC_PLL_B = 1;
   localparam int OSC_HOCO = 2;
   localparam int OSC_MOCO = 3;
   localparam int OSC_LOCO = 4;
   localparam int OSC_MAIN = 5;
   localparam int OSC_SUB = 6;
   localparam int OSC_WDT = 7;
   localparam int OSC_COUNT = 8;
   localparam logic [7:0] OSC_ALLOW_HIGH = 8'hff;
   localparam logic [7:0] OSC_ALLOW_LOW = 8'hfc;
   localparam logic [7:0] OSC_ALLOW_SUBOSC = 8'hd0;
   // Power state codes reported on the status port
   localparam logic [2:0] ST_NORMAL = 3'h0;
   localparam logic [2:0] ST_SLEEP = 3'h1;
   localparam logic [2:0] ST_SW_STANDBY = 3'h2;
   localparam logic [2:0] ST_SNOOZE = 3'h3;
   localparam logic [2:0] ST_DEEP_STANDBY = 3'h4;
   // Cycles the internal reset request is held after a deep standby wake
   localparam logic [3:0] WAKE_RESET_CYCLES = 4'h4;
endpackage

// ---- include/pmc_wake_if.sv ----
// Interface carrying wake sources between the controller and its wake filter
`timescale 1ns/1ps
interface pmc_wake_if;
   logic [2:0] state;
   logic reset_wake;
   logic irq_wake;
   modport filter (input state, output reset_wake, output irq_wake);
   modport ctrl (output state, input reset_wake, input irq_wake);
endinterface

// ---- test/core_model.sv ----
// Behavioural processor core issuing wait-for-interrupt after a chosen delay
`timescale 1ns/1ps
module core_model (
   input wire logic i_clk,
   input wire logic i_req,
   input wire logic [3:0] i_wait,
   output logic o_wait_instr
);
   logic [3:0] cnt_reg;
   logic busy_reg;
   initial begin
      o_wait_instr = 1'b0;
      busy_reg = 1'b0;
      cnt_reg = 4'h0;
   end
   // One-cycle pulse; a later sleep needs a fresh request
   always @(posedge i_clk) begin
      o_wait_instr <= busy_reg && cnt_reg == 4'h0;
      if (i_req) begin
         busy_reg <= 1'b1;
         cnt_reg <= i_wait;
      end else if (busy_reg && cnt_reg == 4'h0) begin
         busy_reg <= 1'b0;
      end else if (busy_reg) begin
         cnt_reg <= cnt_reg - 4'h1;
      end
   end
endmodule // core_model

// ---- test/test_power_mode_controller.sv ----
// Self-checking bench for the power mode controller
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin errors++; \
   $display("ERROR %s expected %h seen %h", nm, ex, gt); end end
module test_power_mode_controller;
   logic clk, rst, we, sel, dp, snz_en, snz_trig, pin, por, lvd, creq, wait_instr;
   logic [1:0] wd, m, v, opc;
   logic [3:0] cwait;
   logic [7:0] irq, sw_en, dp_en, en, osc;
   logic [2:0] st, st_exp;
   logic run, resume, rreq;
   int errors, n_compared, i, k, n, seed;
   power_mode_controller uut (.i_clk(clk), .i_reset(rst), .i_opc_we(we), .i_opc_wdata(wd),
      .i_standby_select_bit(sel), .i_deep_standby_bit(dp), .i_snooze_enable_bit(snz_en),
      .i_wait_for_interrupt_instr(wait_instr), .i_snooze_trigger(snz_trig), .i_pin_reset(pin),
      .i_por_reset(por), .i_lvd_reset(lvd), .i_irq(irq), .i_standby_wake_en(sw_en),
      .i_deep_wake_en(dp_en), .o_operating_power_ctrl_reg(opc), .o_osc_allowed(osc),
      .o_power_state(st), .o_cpu_clock_run(run), .o_irq_resume(resume),
      .o_system_reset_req(rreq));
   core_model core (.i_clk(clk), .i_req(creq), .i_wait(cwait), .o_wait_instr(wait_instr));
   // Standby states keep only the slow trio whatever the mode
   function automatic logic [7:0] exp_osc(input logic [2:0] s, input logic [1:0] md);
      if (s != pmc_pkg::ST_NORMAL && s != pmc_pkg::ST_SLEEP) return pmc_pkg::OSC_ALLOW_SUBOSC;
      if (md == pmc_pkg::OPC_LOW_SPEED) return pmc_pkg::OSC_ALLOW_LOW;
      if (md == pmc_pkg::OPC_SUBOSC_SPEED) return pmc_pkg::OSC_ALLOW_SUBOSC;
      return pmc_pkg::OSC_ALLOW_HIGH;
   endfunction
   task end_sim;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task wr_opc(input logic [1:0] val);
      @(posedge clk);
      we <= 1'b1;
      wd <= val;
      @(posedge clk);
      we <= 1'b0;
      if (val != 2'h3) m = val;
      @(negedge clk);
   endtask
   // Random core delay covers prompt and slow sleep requests
   task enter(input logic s, input logic d);
      @(posedge clk);
      sel <= s;
      dp <= d;
      creq <= 1'b1;
      cwait <= 4'($random(seed)) & 4'h3;
      @(posedge clk);
      creq <= 1'b0;
      for (n = 0; n < 30 && st === pmc_pkg::ST_NORMAL; n++) @(negedge clk);
      if (n == 30) begin
         errors++;
         $display("ERROR power_state expected low power seen %h", st);
         end_sim;
      end
   endtask
   task pulse(input logic [7:0] iv, input logic [2:0] rs, input logic tr);
      @(posedge clk);
      irq <= iv;
      {lvd, por, pin} <= rs;
      snz_trig <= tr;
      @(posedge clk);
      irq <= 8'h00;
      {lvd, por, pin} <= 3'h0;
      snz_trig <= 1'b0;
      @(negedge clk);
   endtask
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      seed = 32'hecf44002;
      {rst, we, wd, sel, dp, snz_en, snz_trig, pin, por, lvd, creq, cwait} = '0;
      {irq, sw_en, dp_en} = '0;
      rst = 1'b1;
      errors = 0;
      n_compared = 0;
      m = pmc_pkg::OPC_RESET_VALUE;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      `CHK("state", pmc_pkg::ST_NORMAL, st)
      `CHK("osc", 8'hff, osc)
      `CHK("flags", 3'h4, {run, resume, rreq})
      // Every code once, reserved code 3 included, then random
      for (i = 0; i < 12; i++) begin
         v = (i < 4) ? 2'(i) : 2'($random(seed));
         wr_opc(v);
         `CHK("opc", m, opc)
         `CHK("osc", exp_osc(pmc_pkg::ST_NORMAL, m), osc)
      end
      @(posedge clk);
      snz_en <= 1'b1;
      pulse(8'h00, 3'h0, 1'b1);
      `CHK("state", pmc_pkg::ST_NORMAL, st)
      $display("test opc done");
      // Slowest mode before sleeping, as power-minded software would set it
      wr_opc(pmc_pkg::OPC_SUBOSC_SPEED);
      `CHK("opc", pmc_pkg::OPC_SUBOSC_SPEED, opc)
      // Sleep, standby, snooze, deep: entry, ignored wake (not for sleep), real wake
      for (k = 0; k < 4; k++) begin
         en = 8'h01 << ($random(seed) & 7);
         @(posedge clk);
         sw_en <= (k == 3) ? ~en : en;
         dp_en <= (k == 3) ? en : ~en;
         snz_en <= 1'b0;
         enter(k != 0, k == 3);
         if (k == 2) begin
            pulse(8'h00, 3'h0, 1'b1);
            `CHK("state", pmc_pkg::ST_SW_STANDBY, st)
            @(posedge clk);
            snz_en <= 1'b1;
            pulse(8'h00, 3'h0, 1'b1);
         end
         st_exp = (k == 0) ? pmc_pkg::ST_SLEEP : (k == 1) ? pmc_pkg::ST_SW_STANDBY :
            (k == 2) ? pmc_pkg::ST_SNOOZE : pmc_pkg::ST_DEEP_STANDBY;
         `CHK("state", st_exp, st)
         `CHK("osc", exp_osc(st_exp, m), osc)
         `CHK("run", 1'b0, run)
         if (k != 0) pulse(~en, 3'h0, 1'b0);
         `CHK("state", st_exp, st)
         pulse(en, 3'h0, 1'b0);
         `CHK("state", pmc_pkg::ST_NORMAL, st)
         `CHK("resume", k != 3, resume)
         `CHK("run", k != 3, run)
         for (n = 0; n < 20 && rreq === 1'b1; n++) @(negedge clk);
         `CHK("rst_len", (k == 3) ? 4 : 0, n)
         @(negedge clk);
         `CHK("resume", 1'b0, resume)
      end
      $display("test wake done");
      // Each reset source cancels a low power state and beats a pending interrupt
      for (k = 0; k < 3; k++) begin
         wr_opc(pmc_pkg::OPC_LOW_SPEED);
         enter(k != 0, k == 2);
         pulse(8'hff, 3'h1 << k, 1'b0);
         `CHK("state", pmc_pkg::ST_NORMAL, st)
         `CHK("opc", pmc_pkg::OPC_RESET_VALUE, opc)
         `CHK("resume", 1'b0, resume)
         for (n = 0; n < 20 && rreq === 1'b1; n++) @(negedge clk);
         `CHK("rst_len", 4, n)
         m = pmc_pkg::OPC_RESET_VALUE;
      end
      $display("test reset done");
      end_sim;
   end
endmodule // test_power_mode_controller
